//--- tb/cascade_stage.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Following counter stage, enabled by the zero detect of the one before
// ----------------------------------------------------------------
module cascade_stage (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic count_enable_n,
   output logic [7:0] count_q
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= 8'hFF;
      end else if (!count_enable_n) begin
         count_q <= count_q - 8'h01;
      end
   end
endmodule
`default_nettype wire

//--- tb/counter_checker.sv
`timescale 1ns/1ps
`default_nettype none
module counter_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic clear_to_max_n,
   input wire logic async_load_n,
   input wire logic sync_load_n,
   input wire logic count_enable_n,
   input wire logic [7:0] preset_value,
   input wire logic [7:0] count_value,
   input wire logic zero_detect_n
);
   logic [2:0] quiet_q;
   logic run;
   // ----------------------------------------------------------------
   // Pin quiet time
   // ----------------------------------------------------------------
   // Clear and async load are synchronised, so they lag the pins by a few edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         quiet_q <= 3'h0;
      end else if (!clear_to_max_n || !async_load_n) begin
         quiet_q <= 3'h0;
      end else if (quiet_q != 3'h7) begin
         quiet_q <= quiet_q + 3'h1;
      end
   end
   assign run = (quiet_q == 3'h7) && sync_load_n && !count_enable_n;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence apb_setup;
      psel && !penable ##1 psel && penable;
   endsequence
   sequence aload_held;
      (!async_load_n && clear_to_max_n && $stable(preset_value)) [*6];
   endsequence
   a_step_down: assert property (
      run && count_value[3:0] != 4'h0 |=> count_value == $past(count_value) - 8'h01)
      else $error("count did not step down by one");
   a_hold_count: assert property (
      quiet_q == 3'h7 && sync_load_n && count_enable_n |=> !clear_to_max_n || $stable(count_value))
      else $error("count moved while disabled");
   a_zero_flag: assert property (
      !zero_detect_n |-> count_value == 8'h00)
      else $error("zero detect low at nonzero count");
   a_zero_follows: assert property (
      run && count_value == 8'h01 |=> !zero_detect_n)
      else $error("zero detect missing at zero");
   a_sync_preset: assert property (
      quiet_q == 3'h7 && clear_to_max_n && async_load_n && !sync_load_n |=> count_value == $past(preset_value))
      else $error("sync load missed preset");
   a_async_preset: assert property (
      aload_held |-> count_value == preset_value)
      else $error("async load missed preset");
   a_clear_wins: assert property (
      !clear_to_max_n |-> (count_value == 8'hFF || count_value == 8'h99) && zero_detect_n)
      else $error("clear did not force maximum");
   a_wrap_max: assert property (
      run && count_value == 8'h00 |=> count_value == 8'hFF || count_value == 8'h99)
      else $error("no reload of maximum after zero");
   a_digit_borrow: assert property (
      run && count_value[3:0] == 4'h0 && count_value != 8'h00
      |=> count_value == $past(count_value) - 8'h01 || count_value == $past(count_value) - 8'h07)
      else $error("bad borrow from high digit");
   a_one_wait: assert property (
      apb_setup |-> !pready ##1 pready)
      else $error("bus answer not after one wait state");
endmodule
bind presettable_down_counter8 counter_checker u_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pready(pready), .clear_to_max_n(clear_to_max_n), .async_load_n(async_load_n),
   .sync_load_n(sync_load_n), .count_enable_n(count_enable_n), .preset_value(preset_value),
   .count_value(count_value), .zero_detect_n(zero_detect_n));
`default_nettype wire

//--- tb/presettable_down_counter8_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "down_counter_regs.vh"
module presettable_down_counter8_tb_top;
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [31:0] pwdata = 32'h0;
   logic clear_to_max_n = 1'h1;
   logic async_load_n = 1'h1;
   logic sync_load_n = 1'h1;
   logic count_enable_n = 1'h1;
   logic [7:0] preset_value = 8'h00;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready;
   logic pslverr;
   logic zero_detect_n;
   logic irq;
   logic [7:0] count_value;
   logic [7:0] next_count;
   int failures = 0;
   int cmp_count = 0;
   always #4 pclk = ~pclk;
   presettable_down_counter8 #(.ADDR_W(8)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .clear_to_max_n(clear_to_max_n), .async_load_n(async_load_n), .sync_load_n(sync_load_n),
      .count_enable_n(count_enable_n), .preset_value(preset_value), .count_value(count_value),
      .zero_detect_n(zero_detect_n), .irq(irq));
   cascade_stage u_next (.clk(pclk), .rst_n(presetn), .count_enable_n(zero_detect_n), .count_q(next_count));
   // ----------------------------------------------------------------
   // Compare and bus tasks
   // ----------------------------------------------------------------
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_word({31'h0, got}, {31'h0, exp});
   endtask
   task automatic chk_count(input logic [7:0] exp);
      chk_word({24'h0, count_value}, {24'h0, exp});
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      rd = prdata;
      chk_bit(pslverr, err);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   // Load with counting enabled, then take one count step
   task automatic load_step(input logic [7:0] p, input logic [7:0] e);
      @(posedge pclk);
      preset_value <= p;
      sync_load_n <= 1'h0;
      count_enable_n <= 1'h0;
      @(posedge pclk);
      sync_load_n <= 1'h1;
      @(negedge pclk);
      chk_count(p);
      @(posedge pclk);
      count_enable_n <= 1'h1;
      @(negedge pclk);
      chk_count(e);
   endtask
   task automatic final_report;
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      #100000;
      failures++;
      final_report;
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h1, `DC_MASK_OFS, 32'h1, 1'h0);
      @(posedge pclk);
      preset_value <= 8'h03;
      sync_load_n <= 1'h0;
      @(posedge pclk);
      sync_load_n <= 1'h1;
      repeat (3) @(posedge pclk);
      count_enable_n <= 1'h0;
      @(negedge pclk);
      chk_count(8'h03);
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk_count(8'h00);
      chk_bit(zero_detect_n, 1'h0);
      @(posedge pclk);
      count_enable_n <= 1'h1;
      @(negedge pclk);
      chk_count(8'hFF);
      chk_bit(zero_detect_n, 1'h1);
      chk_word({24'h0, next_count}, 32'hFE);
      chk_bit(irq, 1'h1);
      apb(1'h0, `DC_STATUS_OFS, 32'h0, 1'h0);
      chk_word(rd, 32'h13);
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk_bit(irq, 1'h0);
      apb(1'h0, `DC_COUNT_OFS, 32'h0, 1'h0);
      chk_word(rd, 32'h1FF);
      apb(1'h0, 8'h18, 32'h0, 1'h1);
      chk_word(rd, 32'h0);
      load_step(8'h10, 8'h0F);
      $display("test binary done");
      apb(1'h1, `DC_CTRL_OFS, 32'h1, 1'h0);
      load_step(8'h20, 8'h19);
      load_step(8'h00, 8'h99);
      load_step(8'h35, 8'h34);
      $display("test decade done");
      // Clear asserted together with a sync load: the clear must win
      @(posedge pclk);
      clear_to_max_n <= 1'h0;
      sync_load_n <= 1'h0;
      preset_value <= 8'h55;
      @(negedge pclk);
      chk_count(8'h99);
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk_count(8'h99);
      @(posedge pclk);
      clear_to_max_n <= 1'h1;
      sync_load_n <= 1'h1;
      repeat (6) @(posedge pclk);
      @(negedge pclk);
      chk_count(8'h99);
      $display("test clear done");
      @(posedge pclk);
      preset_value <= 8'h42;
      async_load_n <= 1'h0;
      count_enable_n <= 1'h0;
      repeat (8) @(posedge pclk);
      @(negedge pclk);
      chk_count(8'h42);
      @(posedge pclk);
      async_load_n <= 1'h1;
      count_enable_n <= 1'h1;
      repeat (6) @(posedge pclk);
      @(negedge pclk);
      chk_count(8'h42);
      chk_bit(irq, 1'h1);
      apb(1'h0, `DC_STATUS_OFS, 32'h0, 1'h0);
      chk_word(rd, 32'h1F);
      apb(1'h0, `DC_WRAPS_OFS, 32'h0, 1'h0);
      chk_word(rd, 32'h2);
      $display("test async load done");
      final_report;
   end
endmodule
`default_nettype wire

//--- verilog/down_counter_regs.vh
`ifndef DOWN_COUNTER_REGS_VH
`define DOWN_COUNTER_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DC_CTRL_OFS 8'h00
`define DC_COUNT_OFS 8'h04
`define DC_STATUS_OFS 8'h08
`define DC_MASK_OFS 8'h0C
`define DC_PINS_OFS 8'h10
`define DC_WRAPS_OFS 8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DC_CTRL_DECADE_BIT 0
`define DC_COUNT_ZD_BIT 8
`define DC_ST_ZERO_BIT 0
`define DC_ST_WRAP_BIT 1
`define DC_ST_ALOAD_BIT 2
`define DC_ST_CLEAR_BIT 3
`define DC_ST_SLOAD_BIT 4
`define DC_PINS_PRESET_LSB 0
`define DC_PINS_CE_BIT 8
`define DC_PINS_SL_BIT 9
`define DC_PINS_AL_BIT 10
`define DC_PINS_CLR_BIT 11

// ----------------------------------------------------------------
// Widths, counts and reset values
// ----------------------------------------------------------------
`define DC_STATUS_W 5
`define DC_WRAPS_W 16
`define DC_MAX_BINARY 8'hFF
`define DC_MAX_DECADE 8'h99
`define DC_DIGIT_MAX 4'h9
`define DC_CTRL_RST 1'b0
`define DC_MASK_RST 5'h00
`define DC_STATUS_RST 5'h00

`endif

//--- verilog/down_step.v
`timescale 1ns/1ps
`default_nettype none
`include "down_counter_regs.vh"

// One count step down, binary or two BCD digits, wrapping to maximum.
module down_step (
   input wire decade,
   input wire [7:0] value,
   output reg [7:0] next_value,
   output reg wrap
);

   always @* begin
      wrap = (value == 8'h00);
      if (decade) begin
         if (value[3:0] == 4'h0) begin
            if (value[7:4] == 4'h0) begin
               next_value = `DC_MAX_DECADE;
            end else begin
               next_value = {value[7:4] - 4'h1, `DC_DIGIT_MAX};
            end
         end else begin
            next_value = {value[7:4], value[3:0] - 4'h1};
         end
      end else if (wrap) begin
         next_value = `DC_MAX_BINARY;
      end else begin
         next_value = value - 8'h01;
      end
   end

endmodule

`default_nettype wire

//--- verilog/pin_sync.v
`timescale 1ns/1ps
`default_nettype none

// Three-stage synchroniser; the output moves only once the second and
// third stages agree, which rejects a single-cycle glitch.
module pin_sync #(
   parameter [0:0] RESET_VAL = 1'b1
) (
   input wire clk,
   input wire rst_n,
   input wire pin_in,
   output reg level_q
);

   reg s1_q;
   reg s2_q;
   reg s3_q;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= RESET_VAL;
         s2_q <= RESET_VAL;
         s3_q <= RESET_VAL;
         level_q <= RESET_VAL;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            level_q <= s3_q;
         end
      end
   end

endmodule

`default_nettype wire

//--- verilog/presettable_down_counter8.v
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "down_counter_regs.vh"

// ----------------------------------------------------------------
// Presettable 8-stage down counter with APB status and control
// ----------------------------------------------------------------
//
// Behaviour
// - With no preset or clear active and count enable low, the count drops by one on every rising clock edge.
// - With count enable high and no preset or clear active, the count holds.
// - Zero detect goes low while the count is zero and count enable is low, for one clock period.
// - Sync load low loads the preset value at the next clock edge regardless of count enable.
// - Async load low forces the preset value regardless of clock, sync load and count enable; here it is synchronised and acts on later clock edges.
// - The preset value is two BCD digits in decade mode and one binary byte in binary mode.
// - Clear low forces the maximum count, 99 decade or 255 binary, over every other input.
// - A count step from zero reloads the maximum, giving 100 or 256 clocks per full cycle.
// - Clear, async load, sync load and count enable are active low, as is zero detect.
// - Priority is clear, then async load, then sync load, then count enable.
// - In decade mode preset bits 7..4 are the high digit and 3..0 the low digit, MSB highest.
module presettable_down_counter8 #(
   parameter ADDR_W = 8
) (
   input wire pclk,
   input wire presetn,
   input wire [ADDR_W-1:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire clear_to_max_n,
   input wire async_load_n,
   input wire sync_load_n,
   input wire count_enable_n,
   input wire [7:0] preset_value,
   output reg [7:0] count_value,
   output reg zero_detect_n,
   output reg irq
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   wire max_set_n;
   wire max_clr_n;
   wire clear_s;
   wire async_load_s;
   wire [7:0] step_value;
   wire step_wrap;
   wire [7:0] addr_byte;
   wire access;
   wire wr_en;
   wire rd_en;
   reg decade_q;
   reg [7:0] count_d;
   reg zero_detect_d;
   reg [`DC_STATUS_W-1:0] status_q;
   reg [`DC_STATUS_W-1:0] status_d;
   reg [`DC_STATUS_W-1:0] mask_q;
   reg [`DC_STATUS_W-1:0] events;
   reg [`DC_STATUS_W-1:0] rd_clear;
   reg clear_seen_q;
   reg [`DC_WRAPS_W-1:0] wraps_q;
   reg [31:0] rdata_d;
   reg addr_ok;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function [7:0] max_count;
      input decade;
      begin
         if (decade) begin
            max_count = `DC_MAX_DECADE;
         end else begin
            max_count = `DC_MAX_BINARY;
         end
      end
   endfunction

   // Zero-extend a narrow field into a bus word
   function [31:0] word8;
      input [7:0] v;
      begin
         word8 = {24'h000000, v};
      end
   endfunction

   // ----------------------------------------------------------------
   // Control pins
   // ----------------------------------------------------------------
   // Clear is a true asynchronous override. The two maxima differ only in
   // bits 1, 2, 5 and 6, so the binary maximum arrives through one async
   // control and the decade maximum through the other; both load constants.
   // A mode change while clear is held switches the forced value at once.
   assign max_set_n = presetn & (clear_to_max_n | decade_q);
   assign max_clr_n = clear_to_max_n | ~decade_q;

   pin_sync #(
      .RESET_VAL(1'b1)
   ) u_sync_clear (
      .clk(pclk),
      .rst_n(presetn),
      .pin_in(clear_to_max_n),
      .level_q(clear_s)
   );

   // A preset value cannot be forced through an asynchronous reset, so the
   // async load is synchronised and then held over the whole counter
   pin_sync #(
      .RESET_VAL(1'b1)
   ) u_sync_aload (
      .clk(pclk),
      .rst_n(presetn),
      .pin_in(async_load_n),
      .level_q(async_load_s)
   );

   down_step u_step (
      .decade(decade_q),
      .value(count_value),
      .next_value(step_value),
      .wrap(step_wrap)
   );

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   always @* begin
      count_d = count_value;
      if (!clear_s) begin
         count_d = max_count(decade_q);
      end else if (!async_load_s) begin
         count_d = preset_value;
      end else if (!sync_load_n) begin
         count_d = preset_value;
      end else if (!count_enable_n) begin
         count_d = step_value;
      end
   end

   // Registered zero detect: looks at the count that is about to be
   // held and the enable seen now, so it is low across the zero period
   // while the enable stays low. chaining takes it straight in.
   always @* begin
      zero_detect_d = 1'b1;
      if (clear_s && (count_d == 8'h00) && !count_enable_n) begin
         zero_detect_d = 1'b0;
      end
   end

   always @(posedge pclk or negedge max_set_n or negedge max_clr_n) begin
      if (!max_set_n) begin
         count_value <= `DC_MAX_BINARY;
         zero_detect_n <= 1'b1;
      end else if (!max_clr_n) begin
         count_value <= `DC_MAX_DECADE;
         zero_detect_n <= 1'b1;
      end else begin
         count_value <= count_d;
         zero_detect_n <= zero_detect_d;
      end
   end

   // ----------------------------------------------------------------
   // Events
   // ----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clear_seen_q <= 1'b1;
      end else begin
         clear_seen_q <= clear_s;
      end
   end

   always @* begin
      events = {`DC_STATUS_W{1'b0}};
      events[`DC_ST_ZERO_BIT] = zero_detect_n & ~zero_detect_d;
      events[`DC_ST_WRAP_BIT] = clear_s & async_load_s & sync_load_n & ~count_enable_n & step_wrap;
      events[`DC_ST_ALOAD_BIT] = clear_s & ~async_load_s;
      events[`DC_ST_CLEAR_BIT] = clear_seen_q & ~clear_s;
      events[`DC_ST_SLOAD_BIT] = clear_s & async_load_s & ~sync_load_n;
   end

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   // One wait state: pready rises in the second access cycle
   assign access = psel & penable & pready;
   assign wr_en = access & pwrite;
   assign rd_en = access & ~pwrite;
   assign addr_byte = paddr[7:0];

   always @* begin
      rd_clear = {`DC_STATUS_W{1'b0}};
      // Only the bits that the read returned are cleared, so an event
      // landing in the wait state is not lost
      if (rd_en && addr_byte == `DC_STATUS_OFS) begin
         rd_clear = prdata[`DC_STATUS_W-1:0];
      end
      // A new event wins over the read that clears
      status_d = (status_q & ~rd_clear) | events;
   end

   always @* begin
      addr_ok = 1'b1;
      rdata_d = 32'h00000000;
      case (addr_byte)
         `DC_CTRL_OFS: begin
            rdata_d[`DC_CTRL_DECADE_BIT] = decade_q;
         end
         `DC_COUNT_OFS: begin
            rdata_d = word8(count_value);
            rdata_d[`DC_COUNT_ZD_BIT] = zero_detect_n;
         end
         `DC_STATUS_OFS: begin
            rdata_d[`DC_STATUS_W-1:0] = status_q;
         end
         `DC_MASK_OFS: begin
            rdata_d[`DC_STATUS_W-1:0] = mask_q;
         end
         `DC_PINS_OFS: begin
            rdata_d = word8(preset_value);
            rdata_d[`DC_PINS_CE_BIT] = count_enable_n;
            rdata_d[`DC_PINS_SL_BIT] = sync_load_n;
            rdata_d[`DC_PINS_AL_BIT] = async_load_s;
            rdata_d[`DC_PINS_CLR_BIT] = clear_s;
         end
         `DC_WRAPS_OFS: begin
            rdata_d[`DC_WRAPS_W-1:0] = wraps_q;
         end
         default: begin
            addr_ok = 1'b0;
         end
      endcase
      if (ADDR_W > 8) begin
         if (paddr >> 8 != 0) begin
            addr_ok = 1'b0;
            rdata_d = 32'h00000000;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~addr_ok;
         if (psel && penable && !pready && !pwrite) begin
            prdata <= rdata_d;
         end else begin
            prdata <= 32'h00000000;
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Changing the mode leaves the held count as is; software presets
   // a valid BCD value after switching to decade mode.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         decade_q <= `DC_CTRL_RST;
         mask_q <= `DC_MASK_RST;
         status_q <= `DC_STATUS_RST;
         irq <= 1'b0;
      end else begin
         if (wr_en && addr_byte == `DC_CTRL_OFS) begin
            decade_q <= pwdata[`DC_CTRL_DECADE_BIT];
         end
         if (wr_en && addr_byte == `DC_MASK_OFS) begin
            mask_q <= pwdata[`DC_STATUS_W-1:0];
         end
         status_q <= status_d;
         irq <= |(status_d & mask_q);
      end
   end

   // Full-cycle counter saturates rather than wrapping, so a long
   // unattended run never reads back as a small number
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wraps_q <= {`DC_WRAPS_W{1'b0}};
      end else if (wr_en && addr_byte == `DC_WRAPS_OFS) begin
         wraps_q <= {{(`DC_WRAPS_W-1){1'b0}}, events[`DC_ST_WRAP_BIT]};
      end else if (events[`DC_ST_WRAP_BIT] && wraps_q != {`DC_WRAPS_W{1'b1}}) begin
         wraps_q <= wraps_q + {{(`DC_WRAPS_W-1){1'b0}}, 1'b1};
      end
   end

endmodule

`default_nettype wire
